// ### rtl/sis_core.sv
// spi identity, serial number and low power command handling
`timescale 1ns/10ps
module sis_core
  import sis_pkg::*;
#(
  parameter logic [63:0] FACTORY_UID = sis_pkg::UID_DEFAULT
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // spi pins
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  // array address from neighbouring logic, same clock
  input wire logic arr_strobe_i,
  input wire logic [sis_pkg::ARR_AW-1:0] arr_addr_i,
  output logic arr_row_act_o,
  output logic [sis_pkg::ROW_AW-1:0] arr_row_o,
  // state
  output logic [63:0] serial_number_o,
  output sis_pkg::sis_status_t status_o
);
  import sis_pkg::*;

  sis_pins_t pins_s;
  logic sck_d_ff;
  logic cs_d_ff;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic active;
  logic byte_done;
  logic [7:0] nxt_byte;

  sis_pwr_t pwr_ff;
  sis_phase_t phase_ff;
  logic [2:0] bit_cnt_ff;
  logic [7:0] rx_ff;
  logic [2:0] wr_idx_ff;
  logic sn_got_ff;
  logic arm_dpd_ff;
  logic arm_hib_ff;
  logic write_enable_latch_cmd_pend_ff;
  logic wel_ff;
  logic sn_locked_ff;
  logic [63:0] sn_ff;
  logic [7:0] shadow_ff [SN_BYTES];
  logic [63:0] shadow_flat;
  logic sn_commit;
  logic tx_start;
  logic [7:0] tx_sh_ff;
  logic [2:0] tx_bit_ff;
  logic [2:0] tx_byte_ff;
  logic so_ff;
  logic [TW-1:0] csw_cnt_ff;
  logic tmr_load;
  logic [TW-1:0] tmr_count;
  logic tmr_busy;
  logic tmr_done;
  logic [ROW_AW-1:0] row_last_ff;
  logic row_valid_ff;
  logic [ROW_AW-1:0] row_now;
  logic row_act_ff;

  sis_sync #(
    .W(3),
    .RST_VAL(3'b100)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .async_i({cs_n_i, sck_i, si_i}),
    .sync_o(pins_s)
  );

  sis_timer #(
    .TW(TW)
  ) u_timer (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .busy_o(tmr_busy),
    .done_o(tmr_done)
  );

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sck_d_ff <= 1'b0;
      cs_d_ff <= 1'b1;
    end else begin
      sck_d_ff <= pins_s.sck;
      cs_d_ff <= pins_s.cs_n;
    end
  end

  assign active = (pwr_ff == PS_ACTIVE);
  // clock and data gated off asleep
  assign sck_rise = active && !pins_s.cs_n && pins_s.sck && !sck_d_ff;
  assign sck_fall = active && !pins_s.cs_n && !pins_s.sck && sck_d_ff;
  assign cs_fall = !pins_s.cs_n && cs_d_ff;
  assign cs_rise = pins_s.cs_n && !cs_d_ff;
  assign nxt_byte = {rx_ff[6:0], pins_s.si};
  assign byte_done = sck_rise && (bit_cnt_ff == 3'd7) &&
                     (phase_ff == PH_OPCODE || phase_ff == PH_RX_SN);
  assign tx_start = byte_done && (phase_ff == PH_OPCODE) && (nxt_byte == OP_READ_UNIQUE_IDENTIFIER_CMD || nxt_byte == OP_READ_SERIAL_NUMBER_CMD);

  // power state machine
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pwr_ff <= PS_ACTIVE;
    end else begin
      unique case (pwr_ff)
        PS_ACTIVE: begin
          if (cs_rise && arm_dpd_ff) begin
            pwr_ff <= PS_ENT_DPD;
          end else if (cs_rise && arm_hib_ff) begin
            pwr_ff <= PS_ENT_HIB;
          end
        end
        PS_ENT_DPD: if (tmr_done) pwr_ff <= PS_DPD;
        PS_DPD: if (!pins_s.cs_n && csw_cnt_ff == CSW_DPD_CYC - TW'(1)) pwr_ff <= PS_WAKE_DPD;
        PS_WAKE_DPD: if (tmr_done) pwr_ff <= PS_ACTIVE;
        PS_ENT_HIB: if (tmr_done) pwr_ff <= PS_HIB;
        PS_HIB: if (cs_fall) pwr_ff <= PS_WAKE_HIB;
        PS_WAKE_HIB: if (tmr_done) pwr_ff <= PS_ACTIVE;
        default: pwr_ff <= PS_ACTIVE;
      endcase
    end
  end

  always_comb begin
    tmr_load = 1'b0;
    tmr_count = '0;
    if (active && cs_rise && arm_dpd_ff) begin
      tmr_load = 1'b1;
      tmr_count = ENT_DPD_CYC;
    end else if (active && cs_rise && arm_hib_ff) begin
      tmr_load = 1'b1;
      tmr_count = ENT_HIB_CYC;
    end else if (pwr_ff == PS_DPD && !pins_s.cs_n && csw_cnt_ff == CSW_DPD_CYC - TW'(1)) begin
      tmr_load = 1'b1;
      tmr_count = EXT_DPD_CYC;
    end else if (pwr_ff == PS_HIB && cs_fall) begin
      tmr_load = 1'b1;
      tmr_count = EXT_HIB_CYC;
    end
  end

  // select low time while in deep sleep; a short glitch does not wake
  always_ff @(posedge core_clk_i) begin
    if (srst_i || pwr_ff != PS_DPD || pins_s.cs_n) begin
      csw_cnt_ff <= '0;
    end else if (csw_cnt_ff != CSW_DPD_CYC) begin
      csw_cnt_ff <= csw_cnt_ff + TW'(1);
    end
  end

  // frame and opcode decode
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      phase_ff <= PH_IDLE;
      bit_cnt_ff <= 3'd0;
      rx_ff <= 8'h00;
      wr_idx_ff <= 3'd0;
      sn_got_ff <= 1'b0;
      arm_dpd_ff <= 1'b0;
      arm_hib_ff <= 1'b0;
      write_enable_latch_cmd_pend_ff <= 1'b0;
    end else if (pins_s.cs_n) begin
      // frames begun during wakeup stay ignored until the next select fall
      phase_ff <= PH_IDLE;
      arm_dpd_ff <= 1'b0;
      arm_hib_ff <= 1'b0;
      write_enable_latch_cmd_pend_ff <= 1'b0;
      sn_got_ff <= 1'b0;
    end else if (cs_fall && active) begin
      phase_ff <= PH_OPCODE;
      bit_cnt_ff <= 3'd0;
      wr_idx_ff <= 3'd0;
    end else if (sck_rise && (phase_ff == PH_OPCODE || phase_ff == PH_RX_SN)) begin
      rx_ff <= nxt_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'd1;
      if (byte_done && phase_ff == PH_OPCODE) begin
        unique case (nxt_byte)
          OP_READ_UNIQUE_IDENTIFIER_CMD: phase_ff <= PH_TX_UID;
          OP_READ_SERIAL_NUMBER_CMD: phase_ff <= PH_TX_SN;
          OP_WRITE_SERIAL_NUMBER_CMD: phase_ff <= (wel_ff && !sn_locked_ff) ? PH_RX_SN : PH_IGNORE;
          // enable takes effect at select rise
          OP_WRITE_ENABLE_LATCH_CMD: begin
            write_enable_latch_cmd_pend_ff <= 1'b1;
            phase_ff <= PH_IGNORE;
          end
          OP_DPD: begin
            arm_dpd_ff <= 1'b1;
            phase_ff <= PH_IGNORE;
          end
          OP_HBN: begin
            arm_hib_ff <= 1'b1;
            phase_ff <= PH_IGNORE;
          end
          default: phase_ff <= PH_IGNORE;
        endcase
      end else if (byte_done) begin
        wr_idx_ff <= wr_idx_ff + 3'd1;
        sn_got_ff <= 1'b1;
      end
    end
  end

  // serial number burst capture, byte 0 first
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < SN_BYTES; i++) begin
        shadow_ff[i] <= 8'h00;
      end
    end else if (byte_done && phase_ff == PH_OPCODE) begin
      for (int i = 0; i < SN_BYTES; i++) begin
        shadow_ff[i] <= byte_of(sn_ff, 3'(i));
      end
    end else if (byte_done && phase_ff == PH_RX_SN) begin
      shadow_ff[wr_idx_ff] <= nxt_byte;
    end
  end

  always_comb begin
    shadow_flat = '0;
    for (int i = 0; i < SN_BYTES; i++) begin
      shadow_flat[i*8 +: 8] = shadow_ff[i];
    end
  end

  assign sn_commit = active && cs_rise && phase_ff == PH_RX_SN && sn_got_ff;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sn_ff <= SN_RESET;
      sn_locked_ff <= 1'b0;
    end else if (sn_commit && !sn_locked_ff) begin
      sn_ff <= shadow_flat;
      sn_locked_ff <= 1'b1;
    end
  end

  // write enable latch, consumed by a completed serial write
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wel_ff <= 1'b0;
    end else if (cs_rise && write_enable_latch_cmd_pend_ff) begin
      wel_ff <= 1'b1;
    end else if (sn_commit) begin
      wel_ff <= 1'b0;
    end
  end

  // id only from parameter, never written
  // transmit shifter, msb first per byte
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      tx_sh_ff <= 8'h00;
      tx_bit_ff <= 3'd0;
      tx_byte_ff <= 3'd0;
      so_ff <= 1'b0;
    end else if (tx_start) begin
      tx_sh_ff <= byte_of((nxt_byte == OP_READ_SERIAL_NUMBER_CMD) ? sn_ff : FACTORY_UID, 3'd0);
      tx_bit_ff <= 3'd0;
      tx_byte_ff <= 3'd1;
    end else if (sck_fall && (phase_ff == PH_TX_UID || phase_ff == PH_TX_SN)) begin
      so_ff <= tx_sh_ff[7];
      tx_bit_ff <= tx_bit_ff + 3'd1;
      if (tx_bit_ff == 3'd7) begin
        tx_sh_ff <= byte_of((phase_ff == PH_TX_SN) ? sn_ff : FACTORY_UID, tx_byte_ff);
        tx_byte_ff <= tx_byte_ff + 3'd1;
      end else begin
        tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
    end
  end

  // driven only when active and selected
  assign so_oe_o = active && !pins_s.cs_n && (phase_ff == PH_TX_UID || phase_ff == PH_TX_SN);
  assign so_o = so_ff;

  // one row touch per change of row within a frame; a strobe repeating the last row is suppressed
  assign row_now = arr_addr_i[ROW_LSB +: ROW_AW];
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      row_last_ff <= '0;
      row_valid_ff <= 1'b0;
      row_act_ff <= 1'b0;
    end else begin
      row_act_ff <= arr_strobe_i && (!row_valid_ff || row_now != row_last_ff);
      if (pins_s.cs_n) begin
        row_valid_ff <= 1'b0;
      end else if (arr_strobe_i) begin
        row_valid_ff <= 1'b1;
        row_last_ff <= row_now;
      end
    end
  end

  assign arr_row_act_o = row_act_ff;
  assign arr_row_o = row_last_ff;
  assign serial_number_o = sn_ff;
  assign status_o = '{deep_down: (pwr_ff == PS_DPD), hibernate: (pwr_ff == PS_HIB),
                      waking: (pwr_ff == PS_WAKE_DPD || pwr_ff == PS_WAKE_HIB),
                      wel: wel_ff, sn_locked: sn_locked_ff};

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  property p_sleep_hiz;
    !active |-> !so_oe_o;
  endproperty
  a_sleep_hiz: assert property (p_sleep_hiz) else $error("output driven while asleep");

  property p_wake_hiz;
    $rose(pwr_ff == PS_WAKE_DPD) |-> !so_oe_o [*8];
  endproperty
  a_wake_hiz: assert property (p_wake_hiz) else $error("output driven in deep sleep wakeup");

  property p_dpd_enter;
    (pwr_ff == PS_ENT_DPD) && tmr_done |=> pwr_ff == PS_DPD;
  endproperty
  a_dpd_enter: assert property (p_dpd_enter) else $error("deep sleep not entered after delay");

  property p_hib_enter;
    active && cs_rise && arm_hib_ff && !arm_dpd_ff |=> pwr_ff == PS_ENT_HIB ##[1:40] pwr_ff == PS_HIB;
  endproperty
  a_hib_enter: assert property (p_hib_enter) else $error("hibernate entry late");

  property p_hib_wake;
    (pwr_ff == PS_HIB) && cs_fall |=> pwr_ff == PS_WAKE_HIB;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate wake not started");

  property p_sn_otp;
    sn_locked_ff |=> $stable(sn_ff);
  endproperty
  a_sn_otp: assert property (p_sn_otp) else $error("locked serial number changed");

  property p_no_wel;
    byte_done && phase_ff == PH_OPCODE && nxt_byte == OP_WRITE_SERIAL_NUMBER_CMD && !wel_ff |=> phase_ff == PH_IGNORE;
  endproperty
  a_no_wel: assert property (p_no_wel) else $error("serial write accepted without enable");

  property p_commit;
    sn_commit && !sn_locked_ff |=> sn_locked_ff && sn_ff == $past(shadow_flat) && !wel_ff;
  endproperty
  a_commit: assert property (p_commit) else $error("serial write not committed");

  property p_uid_first;
    tx_start && nxt_byte == OP_READ_UNIQUE_IDENTIFIER_CMD |=> tx_sh_ff == FACTORY_UID[7:0];
  endproperty
  a_uid_first: assert property (p_uid_first) else $error("factory_unique_identifier byte 0 not first");

  property p_sn_wrap;
    sck_fall && phase_ff == PH_TX_SN && tx_bit_ff == 3'd7 && tx_byte_ff == 3'd0 |=> tx_sh_ff == sn_ff[7:0];
  endproperty
  a_sn_wrap: assert property (p_sn_wrap) else $error("serial read did not wrap");

  property p_row_once;
    arr_strobe_i && row_valid_ff && !pins_s.cs_n && row_now == row_last_ff |=> !arr_row_act_o;
  endproperty
  a_row_once: assert property (p_row_once) else $error("row touched twice");

endmodule : sis_core

// ### rtl/sis_pkg.sv
// shared constants, types and helpers of the identity and sleep command block
package sis_pkg;

  // opcodes
  localparam logic [7:0] OP_READ_UNIQUE_IDENTIFIER_CMD = 8'h4C;
  localparam logic [7:0] OP_WRITE_SERIAL_NUMBER_CMD = 8'hC2;
  localparam logic [7:0] OP_READ_SERIAL_NUMBER_CMD = 8'hC3;
  localparam logic [7:0] OP_WRITE_ENABLE_LATCH_CMD = 8'h06;
  localparam logic [7:0] OP_DPD = 8'hBA;
  localparam logic [7:0] OP_HBN = 8'hB9;

  // identity stores
  localparam int SN_BYTES = 8;
  localparam logic [63:0] SN_RESET = 64'h0000_0000_0000_0000;
  // arbitrary neutral value, replaced per die at manufacture
  localparam logic [63:0] UID_DEFAULT = 64'h0123_4567_89AB_CDEF;

  // array organisation
  localparam int ROW_COUNT = 32768;
  localparam int ROW_BITS = 64;
  localparam int ROW_AW = 15;
  localparam int ROW_LSB = 3;
  localparam int ARR_AW = 19;

  // timing, in ns at the core clock
  localparam int T_CLK_NS = 100;
  localparam int T_ENT_DPD_NS = 3000;
  localparam int T_CSW_DPD_NS = 1000;
  localparam int T_EXT_DPD_NS = 10000;
  localparam int T_ENT_HIB_NS = 3000;
  localparam int T_EXT_HIB_NS = 300000;

  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns + T_CLK_NS - 1) / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_ceil

  function automatic int cyc_floor(input int ns);
    int c;
    c = ns / T_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : cyc_floor

  localparam int TW = 16;
  localparam logic [TW-1:0] ENT_DPD_CYC = TW'(cyc_ceil(T_ENT_DPD_NS));
  localparam logic [TW-1:0] CSW_DPD_CYC = TW'(cyc_ceil(T_CSW_DPD_NS));
  localparam logic [TW-1:0] EXT_DPD_CYC = TW'(cyc_floor(T_EXT_DPD_NS));
  localparam logic [TW-1:0] ENT_HIB_CYC = TW'(cyc_ceil(T_ENT_HIB_NS));
  localparam logic [TW-1:0] EXT_HIB_CYC = TW'(cyc_floor(T_EXT_HIB_NS));

  typedef enum logic [2:0] {PS_ACTIVE, PS_ENT_DPD, PS_DPD, PS_WAKE_DPD, PS_ENT_HIB, PS_HIB, PS_WAKE_HIB} sis_pwr_t;
  typedef enum logic [2:0] {PH_IDLE, PH_OPCODE, PH_TX_UID, PH_TX_SN, PH_RX_SN, PH_IGNORE} sis_phase_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } sis_pins_t;

  typedef struct packed {
    logic deep_down;
    logic hibernate;
    logic waking;
    logic wel;
    logic sn_locked;
  } sis_status_t;

  function automatic logic [7:0] byte_of(input logic [63:0] v, input logic [2:0] idx);
    return v[{idx, 3'b000} +: 8];
  endfunction : byte_of

endpackage : sis_pkg

// ### rtl/sis_sync.sv
// two-flop synchroniser for the spi pins
`timescale 1ns/10ps
module sis_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // async in, synced out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      meta_ff <= RST_VAL;
      sync_ff <= RST_VAL;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule : sis_sync

// ### rtl/sis_timer.sv
// down counter for power state entry and exit delays
`timescale 1ns/10ps
module sis_timer #(
  parameter int TW = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // load and status
  input wire logic load_i,
  input wire logic [TW-1:0] count_i,
  output logic busy_o,
  output logic done_o
);

  logic [TW-1:0] cnt_ff;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_ff <= '0;
    end else if (load_i) begin
      cnt_ff <= count_i;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - TW'(1);
    end
  end

  assign busy_o = (cnt_ff != '0);
  // pulse on the last counted cycle, so load-to-done is count_i cycles
  assign done_o = (cnt_ff == TW'(1)) && !load_i;

endmodule : sis_timer

// ### tb/sis_spi_host.sv
// spi bus master model for the identity and sleep command block
`timescale 1ns/10ps
module sis_spi_host #(
  parameter int HALF = 8
) (
  // clock
  input wire logic core_clk_i,
  // spi pins
  input wire logic so_i,
  input wire logic so_oe_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic si_o
);
  import sis_pkg::*;

  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    si_o = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : idle

  task automatic sel(input logic lvl);
    idle(4);
    cs_n_o = lvl;
    idle(12);
  endtask : sel

  // mode 0, half period kept well above the 4-clock minimum
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_o = tx[i];
      idle(HALF);
      // a floating line reads inverted so a stale bit cannot pass
      rx[i] = so_oe_i ? so_i : ~so_i;
      sck_o = 1'b1;
      idle(HALF);
      sck_o = 1'b0;
    end
  endtask : xfer

  task automatic frame(input logic [7:0] op, input int n, input logic [63:0] wd, output logic [63:0] rd);
    logic [7:0] b;
    rd = 64'h0;
    sel(1'b0);
    xfer(op, b);
    for (int k = 0; k < n; k++) begin
      xfer(wd[(k % 8) * 8 +: 8], b);
      rd = {b, rd[63:8]};
    end
    sel(1'b1);
  endtask : frame

  function automatic logic [7:0] crc8(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 55; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction : crc8

  // customer id on top, crc in low byte
  task automatic program_sn(input logic [15:0] cust, input logic [39:0] uniq, input logic with_write_enable_latch_cmd);
    logic [63:0] rd;
    // write enable in its own frame
    if (with_write_enable_latch_cmd) frame(OP_WRITE_ENABLE_LATCH_CMD, 0, 64'h0, rd);
    frame(OP_WRITE_SERIAL_NUMBER_CMD, 8, {cust, uniq, crc8({cust, uniq})}, rd);
  endtask : program_sn

  // bare select pulse, clock held still
  task automatic wake_pulse();
    cs_n_o = 1'b0;
    idle(int'(CSW_DPD_CYC) + 4);
    cs_n_o = 1'b1;
    idle(4);
  endtask : wake_pulse

  // wait out the rest of the hibernate exit
  task automatic finish_hib_wake();
    idle(int'(EXT_HIB_CYC) + 20);
  endtask : finish_hib_wake
endmodule : sis_spi_host

// ### tb/tb_top.sv
// self-checking bench for the identity and sleep command block
`timescale 1ns/10ps
module tb_top;
  import sis_pkg::*;
  typedef struct packed {
    logic [ARR_AW-1:0] addr;
    logic act;
    logic [ROW_AW-1:0] row;
  } sis_row_case_t;
  localparam sis_row_case_t ROWS [5] = '{'{19'h00000, 1'h1, 15'h0000}, '{19'h00007, 1'h0, 15'h0000},
    '{19'h00008, 1'h1, 15'h0001}, '{19'h7FFF8, 1'h1, 15'h7FFF}, '{19'h3FFF8, 1'h0, 15'h7FFF}};
  logic core_clk_i, srst_i, cs_n, sck, si, so, so_oe, arr_strobe, arr_row_act;
  logic [ARR_AW-1:0] arr_addr;
  logic [ROW_AW-1:0] arr_row;
  logic [63:0] sn, rd, exp_sn;
  logic [7:0] b;
  sis_status_t st;
  int n_errors = 0;
  int total_checks = 0;

  sis_core sis_core_i (.core_clk_i(core_clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck), .si_i(si),
    .so_o(so), .so_oe_o(so_oe), .arr_strobe_i(arr_strobe), .arr_addr_i(arr_addr),
    .arr_row_act_o(arr_row_act), .arr_row_o(arr_row), .serial_number_o(sn), .status_o(st));
  sis_spi_host sis_spi_host_i (.core_clk_i(core_clk_i), .so_i(so), .so_oe_i(so_oe), .cs_n_o(cs_n),
    .sck_o(sck), .si_o(si));

  initial core_clk_i = 1'b0;
  always #50 core_clk_i = ~core_clk_i;

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  // run needs about 15000 cycles
  initial begin
    #(40000 * 100);
    n_errors++;
    report_and_stop();
  end

  initial begin
    srst_i = 1'b1;
    arr_strobe = 1'b0;
    arr_addr = '0;
    cyc(20);
    srst_i = 1'b0;
    cyc(4);
    sis_spi_host_i.sel(1'b0);
    foreach (ROWS[i]) begin
      arr_addr = ROWS[i].addr;
      arr_strobe = 1'b1;
      cyc(1);
      // the row pulse stands one cycle only, so look before dropping the strobe
      chk("row_act", 64'(arr_row_act), 64'(ROWS[i].act));
      chk("row", 64'(arr_row), 64'(ROWS[i].row));
      arr_strobe = 1'b0;
      cyc(1);
      chk("row_act_end", 64'(arr_row_act), 64'h0);
    end
    sis_spi_host_i.sel(1'b1);
    srst_i = 1'b1;
    cyc(3);
    srst_i = 1'b0;
    cyc(4);
    chk("status", 64'(st), 64'h0);
    chk("sn", sn, SN_RESET);
    chk("so_oe", 64'(so_oe), 64'h0);
    sis_spi_host_i.frame(OP_READ_UNIQUE_IDENTIFIER_CMD, 9, 64'h0, rd);
    chk("uid", rd, {UID_DEFAULT[7:0], UID_DEFAULT[63:8]});
    sis_spi_host_i.program_sn(16'hA5C3, 40'h123456789A, 1'b0);
    chk("sn_no_wel", sn, 64'h0);
    sis_spi_host_i.frame(OP_READ_SERIAL_NUMBER_CMD, 8, 64'h0, rd);
    chk("sn_read_blank", rd, 64'h0);
    exp_sn = {16'hA5C3, 40'h123456789A, sis_spi_host_i.crc8({16'hA5C3, 40'h123456789A})};
    sis_spi_host_i.program_sn(16'hA5C3, 40'h123456789A, 1'b1);
    chk("sn_written", sn, exp_sn);
    chk("locked", 64'(st.sn_locked), 64'h1);
    chk("wel", 64'(st.wel), 64'h0);
    sis_spi_host_i.frame(OP_READ_SERIAL_NUMBER_CMD, 9, 64'h0, rd);
    chk("sn_read", rd, {exp_sn[7:0], exp_sn[63:8]});
    sis_spi_host_i.program_sn(16'h0F0F, 40'hFFFFFFFFFF, 1'b1);
    chk("sn_otp", sn, exp_sn);
    sis_spi_host_i.frame(OP_READ_UNIQUE_IDENTIFIER_CMD, 8, 64'h0, rd);
    chk("uid_fixed", rd, UID_DEFAULT);
    sis_spi_host_i.frame(OP_DPD, 0, 64'h0, rd);
    cyc(10);
    chk("dpd_early", 64'(st.deep_down), 64'h0);
    cyc(20);
    chk("dpd", 64'(st.deep_down), 64'h1);
    // clocks with select high must not disturb sleep
    sis_spi_host_i.xfer(OP_READ_SERIAL_NUMBER_CMD, b);
    chk("dpd_still", 64'(st.deep_down), 64'h1);
    chk("dpd_float", 64'(so_oe), 64'h0);
    sis_spi_host_i.wake_pulse();
    chk("dpd_waking", 64'(st.waking), 64'h1);
    chk("dpd_wake_float", 64'(so_oe), 64'h0);
    cyc(int'(EXT_DPD_CYC) + 10);
    chk("dpd_awake", 64'({st.deep_down, st.waking}), 64'h0);
    sis_spi_host_i.frame(OP_READ_SERIAL_NUMBER_CMD, 8, 64'h0, rd);
    chk("dpd_resume", rd, exp_sn);
    sis_spi_host_i.frame(OP_HBN, 0, 64'h0, rd);
    cyc(10);
    chk("hib_early", 64'(st.hibernate), 64'h0);
    cyc(20);
    chk("hib", 64'(st.hibernate), 64'h1);
    sis_spi_host_i.frame(8'h00, 0, 64'h0, rd);
    chk("hib_waking", 64'(st.waking), 64'h1);
    chk("hib_float", 64'(so_oe), 64'h0);
    sis_spi_host_i.finish_hib_wake();
    chk("hib_awake", 64'({st.hibernate, st.waking}), 64'h0);
    sis_spi_host_i.frame(OP_READ_UNIQUE_IDENTIFIER_CMD, 8, 64'h0, rd);
    chk("hib_resume", rd, UID_DEFAULT);
    report_and_stop();
  end
endmodule : tb_top
